// ==== hw/osc_pkg.sv ====
`default_nettype none
package osc_pkg;
	// clock and counter input limits
	localparam int CLK_HZ = 200_000_000;
	localparam int MAX_COUNT_RATE_HZ = 100;
	localparam int FILTER_CYCLES = 16;
	localparam int FILTER_W = 8;

	// default sizes
	localparam int NUM_AO = 8;
	localparam int AO_W = 16;
	localparam int NUM_DI = 16;
	localparam int COUNT_W = 32;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int LANE_W = 8;
	localparam int MAX_CHANNELS = 16;

	// register map, byte addresses
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_TIMEOUT = 12'h008;
	localparam logic [11:0] OFS_CNT_ENABLE = 12'h00C;
	localparam logic [11:0] OFS_CNT_CLEAR = 12'h010;
	localparam logic [11:0] OFS_IDLE = 12'h014;
	localparam logic [11:0] BASE_POWERON = 12'h040;
	localparam logic [11:0] BASE_SAFE = 12'h080;
	localparam logic [11:0] BASE_LIVE = 12'h0C0;
	localparam logic [11:0] BASE_COUNT = 12'h100;
	localparam int REGION_LSB = 6;
	localparam int INDEX_LSB = 2;
	localparam int INDEX_W = 4;

	// field positions
	localparam int CTRL_RESTART_BIT = 0;
	localparam int CTRL_WDT_CLEAR_BIT = 1;
	localparam int STAT_TRIPPED_BIT = 0;
	localparam int STAT_RUNNING_BIT = 1;

	// reset values
	localparam logic [31:0] TIMEOUT_RESET = 32'h0000_0000;
	localparam logic [31:0] CNT_ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] POWERON_RESET = 32'h0000_0000;
	localparam logic [31:0] SAFE_RESET = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_LOAD = 2'h1,
		ST_RUN = 2'h2
	} osc_state_type;
endpackage
`default_nettype wire

// ==== hw/osc_pulse_counter.sv ====
`default_nettype none
module osc_pulse_counter #(
	parameter int COUNT_W = osc_pkg::COUNT_W,
	parameter int FILTER = osc_pkg::FILTER_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pulseIn,
	input wire logic countEnable,
	input wire logic countClear,
	output logic [COUNT_W-1:0] count
);
	initial begin
		if (FILTER < 1 || FILTER >= (1 << osc_pkg::FILTER_W) || COUNT_W < 1 || COUNT_W > osc_pkg::DATA_W)
			$error("osc_pulse_counter: unsupported parameters");
	end

	localparam logic [osc_pkg::FILTER_W-1:0] FILTER_LAST = osc_pkg::FILTER_W'(FILTER - 1);

	logic syncFirst;
	logic syncSecond;
	logic filtLevel;
	logic [osc_pkg::FILTER_W-1:0] stableCount;
	logic differs;
	logic settled;
	logic riseEdge;
	logic [COUNT_W-1:0] next_count;

	// a glitch shorter than the filter is dropped; fine for slow inputs only
	assign differs = syncSecond != filtLevel;
	assign settled = differs && (stableCount == FILTER_LAST);
	assign riseEdge = settled && syncSecond;
	assign next_count = countClear ? {COUNT_W{1'b0}} : count + COUNT_W'(riseEdge && countEnable);

	always_ff @(posedge ref_clk) begin
		syncFirst <= pulseIn;
		syncSecond <= syncFirst;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			filtLevel <= 1'b0;
			stableCount <= '0;
			count <= '0;
		end else begin
			if (settled)
				filtLevel <= syncSecond;
			stableCount <= (differs && !settled) ? stableCount + 1'b1 : '0;
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// ==== hw/osc_top.sv ====
// Behaviour
// - after every reset or restart the live value of each analog output is loaded from its power-on value first.
// - writing a power-on value leaves the live output alone until the next restart.
// - when no link traffic arrives for longer than the configured timeout the watchdog trips and forces all outputs.
// - each analog output has its own writable safe value, which it takes while the watchdog is tripped.
// - each digital input may act as a slow pulse counter, guaranteed only below 100 Hz.
// - the per-channel counter-enable register selects the counting inputs, taking effect when written.
// - each counting input shows its current count in the analog-input map.
// - writing a channel's bit in the clear register zeroes that count only.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module osc_top #(
	parameter int NUM_AO = osc_pkg::NUM_AO,
	parameter int AO_W = osc_pkg::AO_W,
	parameter int NUM_DI = osc_pkg::NUM_DI,
	parameter int COUNT_W = osc_pkg::COUNT_W
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [osc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [osc_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [osc_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [osc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [osc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic linkTraffic,
	input wire logic [NUM_DI-1:0] diPin,
	output logic [NUM_AO*AO_W-1:0] aoValue,
	output logic watchdogTripped,
	output logic running
);
	initial begin
		if (NUM_AO < 1 || NUM_AO > osc_pkg::MAX_CHANNELS || NUM_DI < 1 || NUM_DI > osc_pkg::MAX_CHANNELS
			|| AO_W < 1 || AO_W > osc_pkg::DATA_W || COUNT_W < 1 || COUNT_W > osc_pkg::DATA_W)
			$error("osc_top: unsupported parameters");
	end

	localparam int RW = osc_pkg::ADDR_W - osc_pkg::REGION_LSB;
	localparam logic [RW-1:0] REG_CTRLBLK = osc_pkg::OFS_CTRL[osc_pkg::ADDR_W-1:osc_pkg::REGION_LSB];
	localparam logic [RW-1:0] REG_POWERON = osc_pkg::BASE_POWERON[osc_pkg::ADDR_W-1:osc_pkg::REGION_LSB];
	localparam logic [RW-1:0] REG_SAFE = osc_pkg::BASE_SAFE[osc_pkg::ADDR_W-1:osc_pkg::REGION_LSB];
	localparam logic [RW-1:0] REG_LIVE = osc_pkg::BASE_LIVE[osc_pkg::ADDR_W-1:osc_pkg::REGION_LSB];
	localparam logic [RW-1:0] REG_COUNT = osc_pkg::BASE_COUNT[osc_pkg::ADDR_W-1:osc_pkg::REGION_LSB];
	localparam logic [osc_pkg::INDEX_W-1:0] IDX_CTRL = osc_pkg::OFS_CTRL[5:2];
	localparam logic [osc_pkg::INDEX_W-1:0] IDX_STATUS = osc_pkg::OFS_STATUS[5:2];
	localparam logic [osc_pkg::INDEX_W-1:0] IDX_TIMEOUT = osc_pkg::OFS_TIMEOUT[5:2];
	localparam logic [osc_pkg::INDEX_W-1:0] IDX_CNT_ENABLE = osc_pkg::OFS_CNT_ENABLE[5:2];
	localparam logic [osc_pkg::INDEX_W-1:0] IDX_CNT_CLEAR = osc_pkg::OFS_CNT_CLEAR[5:2];
	localparam logic [osc_pkg::INDEX_W-1:0] IDX_IDLE = osc_pkg::OFS_IDLE[5:2];
	// narrow indices for the storage arrays; out-of-range indices are refused by the range checks
	localparam int AO_IW = (NUM_AO > 1) ? $clog2(NUM_AO) : 1;
	localparam int DI_IW = (NUM_DI > 1) ? $clog2(NUM_DI) : 1;

	// the decode assumes one register per word and room for every channel index
	initial begin
		if (osc_pkg::REGION_LSB - osc_pkg::INDEX_LSB != osc_pkg::INDEX_W
			|| (1 << osc_pkg::INDEX_W) < osc_pkg::MAX_CHANNELS)
			$error("osc_top: register map cannot hold the channels");
		if (osc_pkg::FILTER_CYCLES + 2 >= osc_pkg::CLK_HZ / (2 * osc_pkg::MAX_COUNT_RATE_HZ))
			$error("osc_top: input filter too slow for the counted rate");
	end

	function automatic logic [31:0] mergeStrb(input logic [31:0] oldV, input logic [31:0] newV,
		input logic [3:0] strb);
		logic [31:0] res;
		res = oldV;
		for (int b = 0; b < osc_pkg::STRB_W; b++) begin
			if (strb[b])
				res[b*osc_pkg::LANE_W +: osc_pkg::LANE_W] = newV[b*osc_pkg::LANE_W +: osc_pkg::LANE_W];
		end
		return res;
	endfunction

	// write channel: address and data may arrive in either order
	logic awHeld;
	logic wHeld;
	logic [osc_pkg::ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic doWrite;
	logic [RW-1:0] wRegion;
	logic [osc_pkg::INDEX_W-1:0] wIndex;
	logic wCtrlBlk;
	logic wCtrl;
	logic wTimeout;
	logic wEnable;
	logic wClear;
	logic wPoweron;
	logic wSafe;
	logic wLive;
	logic wReadOnly;
	logic wMapped;
	logic [31:0] ctrlBits;
	logic restartReq;
	logic clearTripReq;

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign wRegion = awAddr[osc_pkg::ADDR_W-1:osc_pkg::REGION_LSB];
	assign wIndex = awAddr[osc_pkg::REGION_LSB-1:osc_pkg::INDEX_LSB];
	assign wCtrlBlk = wRegion == REG_CTRLBLK;
	assign wCtrl = doWrite && wCtrlBlk && wIndex == IDX_CTRL;
	assign wTimeout = doWrite && wCtrlBlk && wIndex == IDX_TIMEOUT;
	assign wEnable = doWrite && wCtrlBlk && wIndex == IDX_CNT_ENABLE;
	assign wClear = doWrite && wCtrlBlk && wIndex == IDX_CNT_CLEAR;
	assign wPoweron = doWrite && wRegion == REG_POWERON && 32'(wIndex) < NUM_AO;
	assign wSafe = doWrite && wRegion == REG_SAFE && 32'(wIndex) < NUM_AO;
	assign wLive = doWrite && wRegion == REG_LIVE && 32'(wIndex) < NUM_AO;
	assign wReadOnly = (wCtrlBlk && (wIndex == IDX_STATUS || wIndex == IDX_IDLE))
		|| (wRegion == REG_COUNT && 32'(wIndex) < NUM_DI);
	assign wMapped = wReadOnly || (wCtrlBlk && (wIndex == IDX_CTRL || wIndex == IDX_TIMEOUT
		|| wIndex == IDX_CNT_ENABLE || wIndex == IDX_CNT_CLEAR))
		|| ((wRegion == REG_POWERON || wRegion == REG_SAFE || wRegion == REG_LIVE) && 32'(wIndex) < NUM_AO);
	assign ctrlBits = mergeStrb(32'h0000_0000, wData, wStrb);
	assign restartReq = wCtrl && ctrlBits[osc_pkg::CTRL_RESTART_BIT];
	assign clearTripReq = wCtrl && ctrlBits[osc_pkg::CTRL_WDT_CLEAR_BIT];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			wStrb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= osc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wMapped ? osc_pkg::RESP_OKAY : osc_pkg::RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// control state
	osc_pkg::osc_state_type state;
	osc_pkg::osc_state_type next_state;
	logic [31:0] timeout;
	logic [31:0] idleCount;
	logic [NUM_DI-1:0] cntEnable;
	logic [NUM_DI-1:0] cntClear;
	logic [AO_W-1:0] poweron [NUM_AO];
	logic [AO_W-1:0] safe [NUM_AO];
	logic [AO_W-1:0] live [NUM_AO];
	logic [COUNT_W-1:0] count [NUM_DI];
	logic wdtArmed;
	logic tripEvent;
	logic next_tripped;

	always_comb begin
		case (state)
			osc_pkg::ST_LOAD: next_state = osc_pkg::ST_RUN;
			osc_pkg::ST_RUN: next_state = restartReq ? osc_pkg::ST_LOAD : osc_pkg::ST_RUN;
			default: next_state = osc_pkg::ST_LOAD;
		endcase
	end

	// timeout of zero keeps the watchdog disarmed
	assign wdtArmed = timeout != 32'h0000_0000 && state == osc_pkg::ST_RUN;
	assign tripEvent = wdtArmed && !linkTraffic && idleCount >= timeout;
	// a trip in the clearing cycle survives the clear
	assign next_tripped = tripEvent || (watchdogTripped && !clearTripReq && !restartReq);
	assign running = state == osc_pkg::ST_RUN;
	assign cntClear = wClear ? ctrlBits[NUM_DI-1:0] : '0;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= osc_pkg::ST_LOAD;
			timeout <= osc_pkg::TIMEOUT_RESET;
			cntEnable <= NUM_DI'(osc_pkg::CNT_ENABLE_RESET);
			idleCount <= '0;
			watchdogTripped <= 1'b0;
		end else begin
			state <= next_state;
			if (wTimeout)
				timeout <= mergeStrb(timeout, wData, wStrb);
			if (wEnable)
				cntEnable <= NUM_DI'(mergeStrb(32'(cntEnable), wData, wStrb));
			if (linkTraffic || !wdtArmed || watchdogTripped)
				idleCount <= '0;
			else if (idleCount != 32'hFFFF_FFFF)
				idleCount <= idleCount + 32'h0000_0001;
			watchdogTripped <= next_tripped;
		end
	end

	// per-channel analog output storage
	for (genvar c = 0; c < NUM_AO; c++) begin : g_ao
		logic chSel;
		assign chSel = wIndex == osc_pkg::INDEX_W'(c);
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				poweron[c] <= AO_W'(osc_pkg::POWERON_RESET);
				safe[c] <= AO_W'(osc_pkg::SAFE_RESET);
				live[c] <= '0;
			end else begin
				if (wPoweron && chSel)
					poweron[c] <= AO_W'(mergeStrb(32'(poweron[c]), wData, wStrb));
				if (wSafe && chSel)
					safe[c] <= AO_W'(mergeStrb(32'(safe[c]), wData, wStrb));
				if (state == osc_pkg::ST_LOAD)
					live[c] <= poweron[c];
				else if (watchdogTripped || tripEvent)
					live[c] <= safe[c];
				else if (wLive && chSel)
					live[c] <= AO_W'(mergeStrb(32'(live[c]), wData, wStrb));
			end
		end
		assign aoValue[c*AO_W +: AO_W] = live[c];
	end

	// input counters, one per digital input
	for (genvar d = 0; d < NUM_DI; d++) begin : g_di
		osc_pulse_counter #(
			.COUNT_W(COUNT_W),
			.FILTER(osc_pkg::FILTER_CYCLES)
		) u_counter (
			.ref_clk(ref_clk),
			.reset(reset),
			.pulseIn(diPin[d]),
			.countEnable(cntEnable[d]),
			.countClear(cntClear[d]),
			.count(count[d])
		);
	end

	// read channel
	logic [RW-1:0] rRegion;
	logic [osc_pkg::INDEX_W-1:0] rIndex;
	logic rCtrlBlk;
	logic rAoOk;
	logic rDiOk;
	logic [31:0] rCtrlData;
	logic [31:0] rAoData;
	logic [31:0] rData;
	logic rMapped;
	logic [31:0] statusWord;
	logic [AO_IW-1:0] rAoIdx;
	logic [DI_IW-1:0] rDiIdx;

	assign rRegion = s_axi_araddr[osc_pkg::ADDR_W-1:osc_pkg::REGION_LSB];
	assign rIndex = s_axi_araddr[osc_pkg::REGION_LSB-1:osc_pkg::INDEX_LSB];
	assign rCtrlBlk = rRegion == REG_CTRLBLK;
	assign rAoOk = 32'(rIndex) < NUM_AO;
	assign rDiOk = 32'(rIndex) < NUM_DI;
	assign rAoIdx = rIndex[AO_IW-1:0];
	assign rDiIdx = rIndex[DI_IW-1:0];
	assign statusWord = (32'(watchdogTripped) << osc_pkg::STAT_TRIPPED_BIT)
		| (32'(running) << osc_pkg::STAT_RUNNING_BIT);
	assign rCtrlData = (rIndex == IDX_STATUS) ? statusWord
		: (rIndex == IDX_TIMEOUT) ? timeout
		: (rIndex == IDX_CNT_ENABLE) ? 32'(cntEnable)
		: (rIndex == IDX_IDLE) ? idleCount
		: 32'h0000_0000;
	// pulse registers read as zero
	assign rAoData = !rAoOk ? 32'h0000_0000
		: (rRegion == REG_POWERON) ? 32'(poweron[rAoIdx])
		: (rRegion == REG_SAFE) ? 32'(safe[rAoIdx])
		: 32'(live[rAoIdx]);
	assign rData = rCtrlBlk ? rCtrlData
		: (rRegion == REG_COUNT && rDiOk) ? 32'(count[rDiIdx])
		: rAoData;
	assign rMapped = (rCtrlBlk && (rIndex == IDX_CTRL || rIndex == IDX_STATUS || rIndex == IDX_TIMEOUT
		|| rIndex == IDX_CNT_ENABLE || rIndex == IDX_CNT_CLEAR || rIndex == IDX_IDLE))
		|| (rRegion == REG_COUNT && rDiOk)
		|| ((rRegion == REG_POWERON || rRegion == REG_SAFE || rRegion == REG_LIVE) && rAoOk);
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= osc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rMapped ? rData : 32'h0000_0000;
			s_axi_rresp <= rMapped ? osc_pkg::RESP_OKAY : osc_pkg::RESP_SLVERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== sim/osc_top_monitor.sv ====
`default_nettype none
module osc_top_monitor #(
	parameter int NUM_AO = osc_pkg::NUM_AO,
	parameter int AO_W = osc_pkg::AO_W
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [osc_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic linkTraffic,
	input wire logic [NUM_AO*AO_W-1:0] aoValue,
	input wire logic watchdogTripped,
	input wire logic running
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// power-on values reset to zero, so the first load shows zeros
	load_after_reset_a: assert property ($fell(reset) |-> !running ##1 (running && aoValue == '0))
		else $error("first load after reset missing");
	load_one_cycle_a: assert property (!running && !reset |=> running)
		else $error("load state lasted more than one cycle");
	trip_no_traffic_a: assert property (linkTraffic && !watchdogTripped |=> !watchdogTripped)
		else $error("watchdog tripped in a cycle with traffic");
	// no write can land next edge when no data word is pending
	trip_sticky_a: assert property (watchdogTripped && !s_axi_wvalid && s_axi_wready |=> watchdogTripped)
		else $error("watchdog trip dropped without a clear");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer withdrawn early");
	read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated after handshake");
	cover property ($rose(watchdogTripped));
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(running));
endmodule
bind osc_top osc_top_monitor #(.NUM_AO(NUM_AO), .AO_W(AO_W)) osc_top_monitor_i (.ref_clk, .reset, .s_axi_awready,
	.s_axi_wready, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .linkTraffic, .aoValue, .watchdogTripped, .running);
`default_nettype wire

// ==== sim/osc_link_master.sv ====
`default_nettype none
module osc_link_master (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic active,
	output var logic linkTraffic
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] gap;
	// one frame every eight cycles keeps the idle count far below the timeout
	always_ff @(posedge ref_clk) begin
		gap <= reset ? 3'h0 : gap + 3'h1;
		linkTraffic <= !reset && active && gap == 3'h0;
	end
endmodule
`default_nettype wire

// ==== sim/output_safe_and_input_pulse_counter_test.sv ====
`default_nettype none
module output_safe_and_input_pulse_counter_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0, reset = 1'h1, active = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic linkTraffic, watchdogTripped, running;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] diPin = 16'h0;
	logic [127:0] aoValue;
	logic [15:0] pv [8], sv [8], z [8];
	int err_total = 0, comparisons = 0, n;
	osc_top osc_top_i (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .linkTraffic, .diPin, .aoValue,
		.watchdogTripped, .running);
	osc_link_master osc_link_master_i (.ref_clk, .reset, .active, .linkTraffic);
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task ao_chk(input logic [15:0] e [8]);
		for (int c = 0; c < 8; c++) chk(32'(aoValue[c*16+:16]), 32'(e[c]));
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge ref_clk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge ref_clk);
			if (ah) s_axi_awvalid <= 1'h0;
			if (wh) s_axi_wvalid <= 1'h0;
		end while (!bh);
		s_axi_bready <= 1'h0;
	endtask
	task rd_reg(input logic [11:0] a);
		logic ah, rh;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(negedge ref_clk);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge ref_clk);
			if (ah) s_axi_arvalid <= 1'h0;
		end while (!rh);
		s_axi_rready <= 1'h0;
	endtask
	function automatic logic [31:0] cnt_exp(int d, logic [15:0] en, logic [15:0] clr);
		return (en[d] && !clr[d]) ? 32'(n) : 32'h0;
	endfunction
	task tally_and_finish;
		$display("mismatches %0d, comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'hD5A5));
		z = '{default: 16'h0};
		repeat (16) @(posedge ref_clk);
		reset <= 1'h0;
		repeat (2) @(posedge ref_clk);
		chk(32'(running), 32'h1);
		ao_chk(z);
		rd_reg(osc_pkg::OFS_TIMEOUT);
		chk(rd, osc_pkg::TIMEOUT_RESET);
		rd_reg(osc_pkg::OFS_CNT_ENABLE);
		chk(rd, osc_pkg::CNT_ENABLE_RESET);
		rd_reg(osc_pkg::BASE_POWERON + 12'h020);
		chk(32'(rsp), 32'(osc_pkg::RESP_SLVERR));
		wr(12'h3FC, 32'h0);
		chk(32'(rsp), 32'(osc_pkg::RESP_SLVERR));
		for (int c = 0; c < 8; c++) begin
			pv[c] = 16'($urandom);
			wr(osc_pkg::BASE_POWERON + 12'(c * 4), 32'(pv[c]));
		end
		ao_chk(z);
		rd_reg(osc_pkg::BASE_POWERON + 12'h00C);
		chk(rd, 32'(pv[3]));
		wr(osc_pkg::OFS_CTRL, 32'h1);
		repeat (2) @(posedge ref_clk);
		ao_chk(pv);
		active <= 1'h1;
		wr(osc_pkg::OFS_TIMEOUT, 32'h14);
		for (int c = 0; c < 8; c++) begin
			sv[c] = 16'($urandom);
			wr(osc_pkg::BASE_SAFE + 12'(c * 4), 32'(sv[c]));
		end
		repeat (60) @(posedge ref_clk);
		chk(32'(watchdogTripped), 32'h0);
		ao_chk(pv);
		active <= 1'h0;
		repeat (40) @(posedge ref_clk);
		chk(32'(watchdogTripped), 32'h1);
		ao_chk(sv);
		rd_reg(osc_pkg::OFS_STATUS);
		chk(rd, 32'h3);
		wr(osc_pkg::BASE_LIVE + 12'h008, 32'h0000_1234);
		ao_chk(sv);
		wr(osc_pkg::OFS_TIMEOUT, 32'h0);
		wr(osc_pkg::OFS_CTRL, 32'h2);
		chk(32'(watchdogTripped), 32'h0);
		sv[2] = 16'($urandom);
		wr(osc_pkg::BASE_LIVE + 12'h008, 32'(sv[2]));
		ao_chk(sv);
		wr(osc_pkg::OFS_CNT_ENABLE, 32'h0000_000A);
		n = 1 + int'($urandom % 5);
		// disabled channel 0 is pulsed too and must hold
		repeat (n) begin
			@(posedge ref_clk);
			diPin <= 16'h000B;
			repeat (30) @(posedge ref_clk);
			diPin <= 16'h0000;
			repeat (30) @(posedge ref_clk);
		end
		for (int d = 0; d < 4; d++) begin
			rd_reg(osc_pkg::BASE_COUNT + 12'(d * 4));
			chk(rd, cnt_exp(d, 16'h000A, 16'h0));
		end
		wr(osc_pkg::OFS_CNT_CLEAR, 32'h2);
		for (int d = 0; d < 4; d++) begin
			rd_reg(osc_pkg::BASE_COUNT + 12'(d * 4));
			chk(rd, cnt_exp(d, 16'h000A, 16'h0002));
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
